// [dpcfg_top.v]
// register slice for de-pop, DAC start-up, clock-loss reset and pin 1
// assumes a control port delivering byte address, write and read strobes
`timescale 1ns/1ps
`default_nettype none
`include "dpcfg_regs.vh"
module dpcfg_top #(
  parameter integer LOSS_CYC = `DPCFG_LOSS_CYC,
  parameter integer SHORT_CYC = `DPCFG_SHORT_CYC,
  parameter integer LONG_CYC = `DPCFG_LONG_CYC,
  parameter integer DISCH_CYC = `DPCFG_DISCH_CYC
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // control port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // dac start-up handshake
  input wire dac_start_i,
  output reg dac_discharge_o,
  output reg dac_power_o,
  // de-pop decoded settings
  output reg [3:0] hp_series_resistor_sel_o,
  output reg [8:0] hp_resistor_onehot_o,
  output reg [3:0] hp_cap_charge_time_o,
  output reg [9:0] hp_charge_onehot_o,
  // clock loss
  input wire sel_clk_i,
  output reg hard_reset_o,
  // pin 1 sources
  input wire irq_i,
  input wire gen_out_i,
  input wire density_mod_clock_out_i,
  input wire pri_dout_i,
  input wire pri_dout2_i,
  input wire sec_dout2_i,
  input wire sec_bclk_i,
  input wire sec_fsync_i,
  input wire gen_clk_i,
  input wire muxed_dout_i,
  input wire daisy_out_i,
  // pin 1 pad
  input wire pin1_i,
  output wire pin1_o,
  output wire pin1_oe_o,
  output wire general_input_o
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_DISCH = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;
  localparam [1:0] ST_ON = 2'd3;

  reg [7:0] depop_r;
  reg [7:0] misc_r;
  reg [7:0] pin1_r;
  reg [7:0] pin2_r;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [27:0] tmr_r;
  reg [27:0] tmr_nxt;
  reg [7:0] rd_nxt;
  wire lost;

  // register writes; read-only bits masked so they stay zero
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      depop_r <= `DPCFG_RST_DEPOP;
      misc_r <= `DPCFG_RST_MISC;
      pin1_r <= `DPCFG_RST_PIN1;
      pin2_r <= `DPCFG_RST_PIN2;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `DPCFG_ADDR_DEPOP: depop_r <= reg_wdata_i;
        `DPCFG_ADDR_MISC: misc_r <= reg_wdata_i & `DPCFG_MISC_WMASK;
        `DPCFG_ADDR_PIN1: pin1_r <= reg_wdata_i & `DPCFG_PIN_WMASK;
        `DPCFG_ADDR_PIN2: pin2_r <= reg_wdata_i & `DPCFG_PIN_WMASK;
        default: depop_r <= depop_r;
      endcase
    end
  end

  always @* begin
    case (reg_addr_i)
      `DPCFG_ADDR_DEPOP: rd_nxt = depop_r;
      `DPCFG_ADDR_MISC: rd_nxt = misc_r;
      `DPCFG_ADDR_PIN1: rd_nxt = pin1_r;
      `DPCFG_ADDR_PIN2: rd_nxt = pin2_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end

  // de-pop decode; reserved codes give all-zero one-hot
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hp_series_resistor_sel_o <= 4'h0;
      hp_resistor_onehot_o <= 9'h000;
      hp_cap_charge_time_o <= 4'h0;
      hp_charge_onehot_o <= 10'h000;
    end else begin
      hp_series_resistor_sel_o <= depop_r[7:4];
      hp_resistor_onehot_o <= (depop_r[7:4] <= 4'h8) ?
        (9'h001 << depop_r[7:4]) : 9'h000;
      hp_cap_charge_time_o <= depop_r[3:0];
      hp_charge_onehot_o <= (depop_r[3:0] <= 4'h9) ?
        (10'h001 << depop_r[3:0]) : 10'h000;
    end
  end

  // start-up sequencer: optional discharge, optional late power-up
  always @* begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    case (st_r)
      ST_IDLE: begin
        if (dac_start_i) begin
          if (misc_r[`DPCFG_BIT_DISCH]) begin
            st_nxt = ST_DISCH;
            tmr_nxt = DISCH_CYC[27:0];
          end else if (misc_r[`DPCFG_BIT_LATE]) begin
            st_nxt = ST_WAIT;
            tmr_nxt = misc_r[`DPCFG_BIT_LATE_SEL] ?
              LONG_CYC[27:0] : SHORT_CYC[27:0];
          end else begin
            st_nxt = ST_ON;
          end
        end
      end
      ST_DISCH: begin
        if (!dac_start_i) begin
          st_nxt = ST_IDLE;
        end else if (tmr_r <= 28'h000_0001) begin
          if (misc_r[`DPCFG_BIT_LATE]) begin
            st_nxt = ST_WAIT;
            tmr_nxt = misc_r[`DPCFG_BIT_LATE_SEL] ?
              LONG_CYC[27:0] : SHORT_CYC[27:0];
          end else begin
            st_nxt = ST_ON;
          end
        end else begin
          tmr_nxt = tmr_r - 28'h000_0001;
        end
      end
      ST_WAIT: begin
        if (!dac_start_i) begin
          st_nxt = ST_IDLE;
        end else if (tmr_r <= 28'h000_0001) begin
          st_nxt = ST_ON;
        end else begin
          tmr_nxt = tmr_r - 28'h000_0001;
        end
      end
      ST_ON: begin
        if (!dac_start_i) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      tmr_r <= 28'h000_0000;
      dac_discharge_o <= 1'b0;
      dac_power_o <= 1'b0;
      hard_reset_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      dac_discharge_o <= (st_nxt == ST_DISCH);
      dac_power_o <= (st_nxt == ST_ON);
      // one-cycle pulse; the system reset tree stretches it
      hard_reset_o <= lost;
    end
  end

  dpcfg_clock_watch #(
    .LOSS_CYC(LOSS_CYC)
  ) u_watch (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .en_i(misc_r[`DPCFG_BIT_CLKRST]),
    .sel_clk_i(sel_clk_i),
    .lost_o(lost)
  );

  dpcfg_pin_drive u_pin1 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .cfg_i(pin1_r),
    .irq_i(irq_i),
    .gen_out_i(gen_out_i),
    .density_mod_clock_out_i(density_mod_clock_out_i),
    .pri_dout_i(pri_dout_i),
    .pri_dout2_i(pri_dout2_i),
    .sec_dout2_i(sec_dout2_i),
    .sec_bclk_i(sec_bclk_i),
    .sec_fsync_i(sec_fsync_i),
    .gen_clk_i(gen_clk_i),
    .muxed_dout_i(muxed_dout_i),
    .daisy_out_i(daisy_out_i),
    .pin_in_i(pin1_i),
    .pin_o(pin1_o),
    .pin_oe_o(pin1_oe_o),
    .general_input_o(general_input_o)
  );
endmodule
`default_nettype wire

// [dpcfg_regs.vh]
// constants of the de-pop, start-up and pin function register slice
// assumes a register port with byte address, write strobe and data
`ifndef DPCFG_REGS_VH
`define DPCFG_REGS_VH
`define DPCFG_ADDR_DEPOP 8'h06
`define DPCFG_ADDR_MISC 8'h07
`define DPCFG_ADDR_PIN1 8'h0A
`define DPCFG_ADDR_PIN2 8'h0B
`define DPCFG_RST_DEPOP 8'h55
`define DPCFG_RST_MISC 8'h00
`define DPCFG_RST_PIN1 8'h32
`define DPCFG_RST_PIN2 8'h00
`define DPCFG_MISC_WMASK 8'hF0
`define DPCFG_PIN_WMASK 8'hF7
`define DPCFG_BIT_DISCH 7
`define DPCFG_BIT_LATE 6
`define DPCFG_BIT_LATE_SEL 5
`define DPCFG_BIT_CLKRST 4
`define DPCFG_CLK_MHZ 200
`define DPCFG_LOSS_MS 2
`define DPCFG_LATE_SHORT_MS 128
`define DPCFG_LATE_LONG_MS 512
`define DPCFG_DISCH_MS 2
`define DPCFG_CYC_PER_MS (`DPCFG_CLK_MHZ * 1000)
`define DPCFG_LOSS_CYC (`DPCFG_LOSS_MS * `DPCFG_CYC_PER_MS)
`define DPCFG_SHORT_CYC (`DPCFG_LATE_SHORT_MS * `DPCFG_CYC_PER_MS)
`define DPCFG_LONG_CYC (`DPCFG_LATE_LONG_MS * `DPCFG_CYC_PER_MS)
`define DPCFG_DISCH_CYC (`DPCFG_DISCH_MS * `DPCFG_CYC_PER_MS)
`define DPCFG_FN_OFF 4'h0
`define DPCFG_FN_IN 4'h1
`define DPCFG_FN_OUT 4'h2
`define DPCFG_FN_IRQ 4'h3
`define DPCFG_FN_PDM 4'h4
`define DPCFG_FN_PDOUT 4'h5
`define DPCFG_FN_PDOUT2 4'h6
`define DPCFG_FN_SDOUT 4'h7
`define DPCFG_FN_SDOUT2 4'h8
`define DPCFG_FN_SBCLK 4'h9
`define DPCFG_FN_SFSYNC 4'hA
`define DPCFG_FN_GENERAL_CLOCK_OUT 4'hB
`define DPCFG_FN_MUXED 4'hC
`define DPCFG_FN_DAISY 4'hD
`endif

// [dpcfg_pin_drive.v]
// pin function and drive decoder for one general-purpose pin
// assumes source signals synchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
`include "dpcfg_regs.vh"
module dpcfg_pin_drive (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // configuration
  input wire [7:0] cfg_i,
  // sources
  input wire irq_i,
  input wire gen_out_i,
  input wire density_mod_clock_out_i,
  input wire pri_dout_i,
  input wire pri_dout2_i,
  input wire sec_dout2_i,
  input wire sec_bclk_i,
  input wire sec_fsync_i,
  input wire gen_clk_i,
  input wire muxed_dout_i,
  input wire daisy_out_i,
  input wire pin_in_i,
  // pin and input
  output reg pin_o,
  output reg pin_oe_o,
  output reg general_input_o
);
  reg lvl;
  reg drives;
  reg serial;
  reg oe;
  wire [3:0] fn = cfg_i[7:4];
  wire [2:0] drv = cfg_i[2:0];
  always @* begin
    lvl = 1'b0;
    drives = 1'b1;
    serial = 1'b0;
    case (fn)
      `DPCFG_FN_OUT: lvl = gen_out_i;
      `DPCFG_FN_IRQ: lvl = irq_i;
      `DPCFG_FN_PDM: lvl = density_mod_clock_out_i;
      `DPCFG_FN_PDOUT: begin
        lvl = pri_dout_i;
        serial = 1'b1;
      end
      `DPCFG_FN_PDOUT2: begin
        lvl = pri_dout2_i;
        serial = 1'b1;
      end
      `DPCFG_FN_SDOUT, `DPCFG_FN_SDOUT2: begin
        lvl = sec_dout2_i;
        serial = 1'b1;
      end
      `DPCFG_FN_SBCLK: lvl = sec_bclk_i;
      `DPCFG_FN_SFSYNC: lvl = sec_fsync_i;
      `DPCFG_FN_GENERAL_CLOCK_OUT: lvl = gen_clk_i;
      `DPCFG_FN_MUXED: begin
        lvl = muxed_dout_i;
        serial = 1'b1;
      end
      `DPCFG_FN_DAISY: lvl = daisy_out_i;
      // reserved 14/15 and off/input leave the pin undriven
      default: drives = 1'b0;
    endcase
    // weak levels modelled as driven; pad strength lives outside
    if (!drives) begin
      oe = 1'b0;
    end else if (serial) begin
      oe = 1'b1;
    end else begin
      case (drv)
        3'h1: oe = 1'b1;
        3'h2: oe = 1'b1;
        3'h3: oe = ~lvl;
        3'h4: oe = 1'b1;
        3'h5: oe = lvl;
        default: oe = 1'b0;
      endcase
    end
  end
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
      general_input_o <= 1'b0;
    end else begin
      pin_o <= lvl;
      pin_oe_o <= oe;
      general_input_o <= (fn == `DPCFG_FN_IN) ? pin_in_i : 1'b0;
    end
  end
endmodule
`default_nettype wire

// [dpcfg_clock_watch.v]
// clock-loss watchdog: counts cycles with no edge of the selected clock
// assumes the selected clock arrives as a synchronous level sample
`timescale 1ns/1ps
`default_nettype none
`include "dpcfg_regs.vh"
module dpcfg_clock_watch #(
  parameter integer LOSS_CYC = `DPCFG_LOSS_CYC
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // control
  input wire en_i,
  input wire sel_clk_i,
  // result
  output reg lost_o
);
  reg [19:0] cnt_r;
  reg prev_r;
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 20'h0_0000;
      prev_r <= 1'b0;
      lost_o <= 1'b0;
    end else begin
      prev_r <= sel_clk_i;
      lost_o <= 1'b0;
      if (!en_i || prev_r != sel_clk_i) begin
        cnt_r <= 20'h0_0000;
      end else if (cnt_r >= LOSS_CYC[19:0] - 20'h0_0001) begin
        lost_o <= 1'b1;
        cnt_r <= 20'h0_0000;
      end else begin
        cnt_r <= cnt_r + 20'h0_0001;
      end
    end
  end
endmodule
`default_nettype wire

// [dpcfg_top_properties.sv]
// checker for the de-pop, start-up and pin 1 register slice
// bound into dpcfg_top, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dpcfg_props (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // control port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  // dac, de-pop, clock loss
  input wire dac_start_i,
  input wire dac_discharge_o,
  input wire dac_power_o,
  input wire [3:0] hp_series_resistor_sel_o,
  input wire [8:0] hp_resistor_onehot_o,
  input wire [9:0] hp_charge_onehot_o,
  input wire sel_clk_i,
  input wire hard_reset_o,
  // pin 1
  input wire irq_i,
  input wire pri_dout_i,
  input wire pin1_i,
  input wire pin1_o,
  input wire pin1_oe_o,
  input wire general_input_o
);
  // mirrors of the written registers, masked as the slice stores them
  reg [7:0] dep_r, misc_r, pin_r;
  // decodes lag the register by one edge, also right after reset
  reg live_r;
  wire [3:0] fn = pin_r[7:4];
  wire [8:0] rhot = (dep_r[7:4] > 4'h8) ? 9'h000 : 9'h001 << dep_r[7:4];
  wire [9:0] chot = (dep_r[3:0] > 4'h9) ? 10'h000 : 10'h001 << dep_r[3:0];
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dep_r <= 8'h55;
      misc_r <= 8'h00;
      pin_r <= 8'h32;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h06) dep_r <= reg_wdata_i;
      if (reg_addr_i == 8'h07) misc_r <= reg_wdata_i & 8'hF0;
      if (reg_addr_i == 8'h0A) pin_r <= reg_wdata_i & 8'hF7;
    end
  end
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // start edges only: a phase change mid-run must not look like a start
  sequence s_start;
    $rose(dac_start_i) && !dac_power_o && !dac_discharge_o;
  endsequence
  sequence s_pulse;
    hard_reset_o ##1 !hard_reset_o;
  endsequence
  a_misc_read_back: assert property (reg_rd_i && reg_addr_i == 8'h07
    |=> reg_rdata_o == misc_r) else $error("start-up register read wrong");
  a_res_decode: assert property (live_r && $stable(dep_r) |->
    hp_resistor_onehot_o == rhot && hp_series_resistor_sel_o == dep_r[7:4])
    else $error("resistor decode wrong");
  a_charge_decode: assert property (live_r && $stable(dep_r) |->
    hp_charge_onehot_o == chot) else $error("charge decode wrong");
  a_irq_drive: assert property (pin_r == 8'h31 |=>
    pin1_oe_o && pin1_o == $past(irq_i)) else $error("irq pin wrong");
  a_serial_drive: assert property (fn == 4'h5 |=>
    pin1_oe_o && pin1_o == $past(pri_dout_i)) else $error("data pin wrong");
  a_pin_hiz: assert property (fn == 4'h0 || fn == 4'h1 ||
    (pin_r[2:0] == 3'h0 && fn == 4'h2) |=> !pin1_oe_o)
    else $error("pin driven while off");
  a_gen_input: assert property (fn == 4'h1 |=>
    general_input_o == $past(pin1_i)) else $error("input path wrong");
  a_direct_power: assert property (misc_r[7:6] == 2'b00 ##0 s_start
    |=> dac_power_o) else $error("dac power late");
  a_disch_first: assert property (misc_r[7] ##0 s_start |=>
    dac_discharge_o && !dac_power_o) else $error("no discharge phase");
  a_loss_pulse: assert property (hard_reset_o |-> misc_r[4] &&
    sel_clk_i == $past(sel_clk_i, 8) ##0 s_pulse) else $error("bad hard reset");
endmodule
bind dpcfg_top dpcfg_props dpcfg_props_inst (
  .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .dac_start_i(dac_start_i),
  .dac_discharge_o(dac_discharge_o), .dac_power_o(dac_power_o),
  .hp_series_resistor_sel_o(hp_series_resistor_sel_o),
  .hp_resistor_onehot_o(hp_resistor_onehot_o),
  .hp_charge_onehot_o(hp_charge_onehot_o), .sel_clk_i(sel_clk_i),
  .hard_reset_o(hard_reset_o), .irq_i(irq_i), .pri_dout_i(pri_dout_i),
  .pin1_i(pin1_i), .pin1_o(pin1_o), .pin1_oe_o(pin1_oe_o),
  .general_input_o(general_input_o));
`default_nettype wire

// [dpcfg_host.sv]
// host controller model issuing single-byte control port cycles
// assumes strobes taken on the rising edge, driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
module dpcfg_host (
  // clock
  input wire mclk_i,
  // control port
  output logic [7:0] reg_addr_o = 8'h00,
  output logic reg_wr_o = 1'b0,
  output logic [7:0] reg_wdata_o = 8'h00,
  output logic reg_rd_o = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // reserved pin 1 function and drive codes never leave the host
    if (a == 8'h0A && (d[7:4] > 4'hD || d[2:0] > 3'h5)) d = 8'h00;
    if (a == 8'h07) d = d & 8'hF0;
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge mclk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
  endtask
  // slow host: gaps between cycles
  task automatic idle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
endmodule
`default_nettype wire

// [tb_dpcfg_top.sv]
// self-checking bench for the de-pop, start-up and pin 1 slice
// assumes host model drives the port; bench drives the other inputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_dpcfg_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic dac_start = 1'b0;
  logic sel_clk = 1'b0;
  logic [31:0] rnd = 32'h0000_0000;
  integer seed = 32'h21ef_efd6;
  int num_errors = 0;
  int checked = 0;
  int pulses = 0;
  int i, n;
  logic [7:0] v, e8;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, disch, power, hrst, pin_o, pin_oe, gin;
  wire [3:0] res_sel, chg_sel;
  wire [8:0] res_hot;
  wire [9:0] chg_hot;
  always #2.5 mclk_i = ~mclk_i;
  always @(negedge mclk_i) rnd <= $random(seed);
  dpcfg_host dpcfg_host_inst (.mclk_i(mclk_i), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
  // short counts keep the run brief
  dpcfg_top #(.LOSS_CYC(20), .SHORT_CYC(30), .LONG_CYC(60), .DISCH_CYC(8))
  dpcfg_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .dac_start_i(dac_start), .dac_discharge_o(disch), .dac_power_o(power),
    .hp_series_resistor_sel_o(res_sel), .hp_resistor_onehot_o(res_hot),
    .hp_cap_charge_time_o(chg_sel), .hp_charge_onehot_o(chg_hot),
    .sel_clk_i(sel_clk),
    .hard_reset_o(hrst), .irq_i(rnd[0]), .gen_out_i(rnd[1]),
    .density_mod_clock_out_i(rnd[2]), .pri_dout_i(rnd[3]),
    .pri_dout2_i(rnd[4]), .sec_dout2_i(rnd[5]), .sec_bclk_i(rnd[6]),
    .sec_fsync_i(rnd[7]), .gen_clk_i(rnd[8]), .muxed_dout_i(rnd[9]),
    .daisy_out_i(rnd[10]), .pin1_i(rnd[11]), .pin1_o(pin_o),
    .pin1_oe_o(pin_oe), .general_input_o(gin));
  always @(posedge mclk_i) rd_d <= rd;
  always @(posedge mclk_i) if (hrst === 1'b1) pulses++;
  always @(negedge mclk_i) begin
    if (rd_d) begin
      e8 = exp_q.pop_front();
      `CHK("rdata", e8, rdata)
    end
  end
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    dpcfg_host_inst.rd(a);
  endtask
  task automatic dac_run(input logic [7:0] m, input int lo, input int hi);
    dpcfg_host_inst.wr(8'h07, m);
    rdx(8'h07, m);
    @(negedge mclk_i) dac_start = 1'b1;
    n = 0;
    while (power !== 1'b1 && n < 200) begin
      @(posedge mclk_i) #1 n++;
    end
    if (n == 200) begin num_errors++; close_out; end
    `CHK("dac_delay", 1'b1, n >= lo && n <= hi)
    @(negedge mclk_i) dac_start = 1'b0;
    repeat (4) @(negedge mclk_i);
  endtask
  // expected {oe, level} of pin 1 for a setting and the source bits
  function automatic logic [1:0] pin_exp(input logic [7:0] c,
      input logic [31:0] r);
    logic lv;
    logic on;
    logic ser;
    lv = 1'b0;
    on = 1'b1;
    ser = (c[7:4] >= 4'h5 && c[7:4] <= 4'h8) || c[7:4] == 4'hC;
    case (c[7:4])
      4'h2: lv = r[1];
      4'h3: lv = r[0];
      4'h4: lv = r[2];
      4'h5: lv = r[3];
      4'h6: lv = r[4];
      4'h7, 4'h8: lv = r[5];
      4'h9: lv = r[6];
      4'hA: lv = r[7];
      4'hB: lv = r[8];
      4'hC: lv = r[9];
      4'hD: lv = r[10];
      default: on = 1'b0;
    endcase
    if (ser) begin
      pin_exp = {on, lv};
    end else begin
      case (c[2:0])
        3'h1, 3'h2, 3'h4: pin_exp = {on, lv};
        3'h3: pin_exp = {on & ~lv, lv};
        3'h5: pin_exp = {on & lv, lv};
        default: pin_exp = {1'b0, lv};
      endcase
    end
  endfunction
  task close_out;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i) rst_i = 1'b0;
    rdx(8'h06, 8'h55);
    rdx(8'h07, 8'h00);
    rdx(8'h0A, 8'h32);
    rdx(8'h08, 8'h00);
    for (i = 0; i < 16; i++) begin
      v = {i[3:0], 4'hF - i[3:0]};
      dpcfg_host_inst.wr(8'h06, v);
      rdx(8'h06, v);
      `CHK("depop_raw", v, {res_sel, chg_sel})
      `CHK("res", i < 9 ? 9'h001 << i : 9'h000, res_hot)
      `CHK("chg", i > 5 ? 10'h001 << 15 - i : 10'h000, chg_hot)
    end
    // every function code, bit 3 set to see it read back as zero
    for (i = 0; i < 14; i++) begin
      v = {i[3:0], 1'b1, 3'(i % 6)};
      dpcfg_host_inst.wr(8'h0A, v);
      dpcfg_host_inst.idle(6);
      rdx(8'h0A, v & 8'hF7);
      `CHK("pin", pin_exp(v, rnd), {pin_oe, pin_o})
      `CHK("gin", v[7:4] == 4'h1 && rnd[11], gin)
    end
    dpcfg_host_inst.wr(8'h0A, 8'h31);
    dpcfg_host_inst.idle(4);
    dac_run(8'h00, 1, 2);
    dac_run(8'h80, 9, 13);
    dac_run(8'h40, 30, 35);
    dac_run(8'h60, 60, 65);
    dpcfg_host_inst.wr(8'h07, 8'h10);
    repeat (30) @(negedge mclk_i) sel_clk = ~sel_clk;
    `CHK("early_reset", 0, pulses)
    n = 0;
    while (hrst !== 1'b1 && n < 100) begin
      @(posedge mclk_i) #1 n++;
    end
    if (n == 100) begin num_errors++; close_out; end
    `CHK("loss_time", 1'b1, n >= 18 && n <= 26)
    dpcfg_host_inst.wr(8'h07, 8'h00);
    dpcfg_host_inst.idle(40);
    `CHK("reset_count", 1, pulses)
    // reset again mid-run: written values must fall back
    rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    rdx(8'h06, 8'h55);
    rdx(8'h0A, 8'h32);
    `CHK("depop_hot", {9'h020, 10'h020}, {res_hot, chg_hot})
    dpcfg_host_inst.idle(2);
    close_out;
  end
endmodule
`default_nettype wire
